// >>> rtl/bss_pkg.sv
// Purpose: Shared constants and types of the buck start-up sequencer
// Assumes: 25 MHz system clock derived from the internal oscillator
// Notes:   Every timing count is derived here from its time and the clock rate
package bss_pkg;

  // ==========================================================================
  // Clock and oscillator
  localparam int CLK_HZ         = 25000000;
  localparam int CLK_MHZ        = CLK_HZ / 1000000;
  localparam int OSC_HZ         = 300000;
  localparam int OSC_CYC        = CLK_HZ / OSC_HZ;

  // ==========================================================================
  // Start-up timing
  localparam int DELAY_US       = 6800;
  localparam int DELAY_CYC_DEF  = DELAY_US * CLK_MHZ;
  localparam int SAMPLE_MAX_US  = 3400;
  localparam int SAMPLE_CODES   = 256;
  localparam int SAMPLE_STEP_CYC = (SAMPLE_MAX_US * CLK_MHZ) / SAMPLE_CODES;
  localparam int INIT_US        = 100;
  localparam int INIT_CYC       = INIT_US * CLK_MHZ;
  localparam int SS_US          = 13600;
  localparam int SS_STEPS       = 64;
  localparam int SS_STEP_CYC_DEF = (SS_US * CLK_MHZ) / SS_STEPS;
  localparam int DUMMY_RUNS     = 2;

  // ==========================================================================
  // Overcurrent guard
  localparam int TRIP_SCALE     = 2;
  localparam int DAC_FS_MV      = 475;
  localparam int LIMIT_MV       = 300;
  localparam logic [7:0] LIMIT_CODE = 8'((LIMIT_MV * SAMPLE_CODES) / DAC_FS_MV);
  localparam int BLANK_NS       = 200;
  localparam int BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_PW_NS      = 425;
  localparam int MIN_PW_CYC     = (MIN_PW_NS * CLK_MHZ + 999) / 1000;
  localparam int NARROW_LIMIT   = 3;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [6:0] {
    ST_WAIT   = 7'h01,
    ST_DELAY  = 7'h02,
    ST_SAMPLE = 7'h04,
    ST_INIT   = 7'h08,
    ST_SOFT   = 7'h10,
    ST_RUN    = 7'h20,
    ST_HICCUP = 7'h40
  } bss_state_t;

endpackage

// >>> rtl/bss_sync.sv
// Purpose: Three-stage synchroniser for comparator levels
// Assumes: Inputs are asynchronous comparator outputs
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ns
module bss_sync #(
  parameter int W = 6
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } bss_sync_st_t;

  bss_sync_st_t st_r;
  bss_sync_st_t st_nxt;
  logic [W-1:0] q_nxt;

  // ==========================================================================
  // Per-bit agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      assign q_nxt[gi] = (st_r.s2[gi] == st_r.s3[gi]) ? st_r.s3[gi] : st_r.q[gi];
    end
  endgenerate

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q  = q_nxt;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.q;

endmodule // bss_sync

// >>> rtl/bss_lowside.sv
// Purpose: Gate commands, low-side blanking window and pulse stretching
// Assumes: One period tick per oscillator cycle from the sequencer
// Notes:   Stretch pulse is inserted at the start of the period after two narrow periods
`timescale 1ns/1ns
module bss_lowside import bss_pkg::*; (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic switching_i,
  input  wire logic pwm_high_i,
  input  wire logic tick_i,
  input  wire logic stretch_en_i,
  output logic      high_gate_o,
  output logic      low_gate_o,
  output logic      mon_o
);

  typedef struct packed {
    logic       hs;
    logic       ls;
    logic       mon;
    logic [3:0] on_cnt;
    logic [3:0] blank;
    logic [1:0] narrow;
    logic [3:0] stretch;
  } bss_ls_st_t;

  bss_ls_st_t st_r;
  bss_ls_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!switching_i) begin
      st_nxt = '0;
    end else begin
      if (tick_i) begin
        st_nxt.on_cnt = '0;
        if (st_r.on_cnt < 4'(MIN_PW_CYC)) begin
          st_nxt.narrow = st_r.narrow + 2'h1;
        end else begin
          st_nxt.narrow = '0;
        end
        if (st_nxt.narrow == 2'(NARROW_LIMIT - 1) && stretch_en_i) begin
          st_nxt.stretch = 4'(MIN_PW_CYC);
          st_nxt.narrow  = '0;
        end
      end
      if (st_nxt.stretch != 4'h0) begin
        st_nxt.ls      = 1'b1;
        st_nxt.hs      = 1'b0;
        st_nxt.stretch = st_nxt.stretch - 4'h1;
      end else begin
        st_nxt.ls = ~pwm_high_i;
        st_nxt.hs = pwm_high_i;
      end
      if (st_nxt.ls && st_nxt.on_cnt != 4'hf) begin
        st_nxt.on_cnt = st_nxt.on_cnt + 4'h1;
      end
    end
    st_nxt.blank = (st_nxt.ls && st_r.ls && st_r.blank != 4'hf) ? st_r.blank + 4'h1 : 4'h0;
    st_nxt.mon   = st_nxt.ls && st_r.ls && (st_r.blank >= 4'(BLANK_CYC - 1));
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign high_gate_o = st_r.hs;
  assign low_gate_o  = st_r.ls;
  assign mon_o       = st_r.mon;

  // ==========================================================================
  // Checks
  property p_blank;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(st_r.ls) |-> (!st_r.mon) [*5] ##1 (st_r.mon || !st_r.ls);
  endproperty
  a_blank: assert property (p_blank) else $error("blanking window wrong");

  property p_window_end;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !st_r.ls |-> !st_r.mon;
  endproperty
  a_window_end: assert property (p_window_end) else $error("monitor outside pulse");

  property p_stretch_width;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.stretch == 4'h0 ##1 st_r.stretch != 4'h0) |-> ##9 (st_r.ls || !switching_i);
  endproperty
  a_stretch_width: assert property (p_stretch_width) else $error("stretch too short");

  property p_no_stretch;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (!stretch_en_i && st_r.stretch == 4'h0) |=> (st_r.stretch == 4'h0);
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("stretch while unguarded");

endmodule // bss_lowside

// >>> rtl/bss_seq_top.sv
// Purpose: Start-up, soft-start and overcurrent sequencer of a buck controller
// Assumes: Analog levels arrive as comparator outputs; DACs sit outside
// Notes:   Long delays are parameters so a simulation can shorten them
`timescale 1ns/1ns
module bss_seq_top import bss_pkg::*; #(
  parameter int DELAY_CYC   = DELAY_CYC_DEF,
  parameter int SS_STEP_CYC = SS_STEP_CYC_DEF
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       bias_por_cmp_i,
  input  wire logic       en_cmp_i,
  input  wire logic       samp_cmp_i,
  input  wire logic       prebias_cmp_i,
  input  wire logic       trip_cmp_i,
  input  wire logic       pwm_high_cmp_i,
  output logic            high_side_gate_o,
  output logic            low_side_gate_o,
  output logic            low_drv_en_o,
  output logic            sense_src_en_o,
  output logic [7:0]      set_point_code_o,
  output logic [8:0]      trip_dac_code_o,
  output logic [6:0]      ss_ref_code_o,
  output logic            ea_en_o,
  output logic            osc_run_o,
  output logic            guard_off_o,
  output logic            ss_done_o,
  output logic            hiccup_o
);

  typedef struct packed {
    bss_state_t state;
    logic [17:0] timer;
    logic [7:0]  code;
    logic [8:0]  trip_code;
    logic [6:0]  ss_step;
    logic [6:0]  ss_ref;
    logic        dummy;
    logic        gates_on;
    logic        ea_en;
    logic        sense_en;
    logic        guard_off;
    logic        ss_done;
    logic        hiccup;
    logic [6:0]  osc_cnt;
    logic        tick;
    logic        osc_run;
    logic        drv_en;
  } bss_top_st_t;
  bss_top_st_t st_r;
  bss_top_st_t st_nxt;
  logic [5:0]  syn;
  logic        por_s;
  logic        en_s;
  logic        samp_s;
  logic        pre_s;
  logic        trip_s;
  logic        pwm_s;
  logic        mon_w;
  logic        live;
  logic        trip_v;
  // ==========================================================================
  // Input synchronisation
  // comparators synchronized
  bss_sync #(.W(6)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({pwm_high_cmp_i, trip_cmp_i, prebias_cmp_i, samp_cmp_i, en_cmp_i,
                 bias_por_cmp_i}),
    .sync_o    (syn)
  );

  assign por_s  = syn[0];
  assign en_s   = syn[1];
  assign samp_s = syn[2];
  assign pre_s  = syn[3];
  assign trip_s = syn[4];
  assign pwm_s  = syn[5];
  assign live   = por_s && en_s;
  assign trip_v = mon_w && trip_s && !st_r.guard_off;

  // ==========================================================================
  // Sequencer
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!live) begin
      st_nxt.state    = ST_WAIT;
      st_nxt.timer    = '0;
      st_nxt.gates_on = 1'b0;
      st_nxt.ea_en    = 1'b0;
      st_nxt.sense_en = 1'b0;
      st_nxt.ss_step  = '0;
      st_nxt.dummy    = 1'b0;
      st_nxt.ss_done  = 1'b0;
      st_nxt.hiccup   = 1'b0;
      st_nxt.osc_run  = 1'b0;
      st_nxt.osc_cnt  = '0;
      if (!por_s) begin
        st_nxt.code      = '0;
        st_nxt.trip_code = '0;
        st_nxt.guard_off = 1'b0;
      end
    end else begin
      st_nxt.osc_run = 1'b1;
      if (st_r.osc_cnt == 7'(OSC_CYC - 1)) begin
        st_nxt.osc_cnt = '0;
        st_nxt.tick    = 1'b1;
      end else begin
        st_nxt.osc_cnt = st_r.osc_cnt + 7'h1;
      end
      case (st_r.state)
        ST_WAIT: begin
          st_nxt.state    = ST_DELAY;
          st_nxt.timer    = '0;
          st_nxt.sense_en = 1'b1;
        end
        ST_DELAY: begin
          if (st_r.timer == 18'(DELAY_CYC - 1)) begin
            st_nxt.state = ST_SAMPLE;
            st_nxt.timer = '0;
            st_nxt.code  = '0;
          end else begin
            st_nxt.timer = st_r.timer + 18'h1;
          end
        end
        ST_SAMPLE: begin
          // counter ramps until DAC meets pin
          if (st_r.timer == 18'(SAMPLE_STEP_CYC - 1)) begin
            st_nxt.timer = '0;
            if (samp_s || st_r.code == 8'hff) begin
              st_nxt.state     = ST_INIT;
              st_nxt.sense_en  = 1'b0;
              st_nxt.guard_off = (st_r.code > LIMIT_CODE);
              st_nxt.trip_code = 9'(TRIP_SCALE * st_r.code);
            end else begin
              st_nxt.code = st_r.code + 8'h1;
            end
          end else begin
            st_nxt.timer = st_r.timer + 18'h1;
          end
        end
        ST_INIT: begin
          if (st_r.timer == 18'(INIT_CYC - 1)) begin
            st_nxt.state   = ST_SOFT;
            st_nxt.timer   = '0;
            st_nxt.ss_step = '0;
            st_nxt.ea_en   = 1'b1;
          end else begin
            st_nxt.timer = st_r.timer + 18'h1;
          end
        end
        ST_SOFT: begin
          if (pre_s) begin
            st_nxt.gates_on = 1'b1;
          end
          if (st_r.timer == 18'(SS_STEP_CYC - 1)) begin
            st_nxt.timer   = '0;
            st_nxt.ss_step = st_r.ss_step + 7'h1;
            if (st_r.ss_step == 7'(SS_STEPS - 1)) begin
              st_nxt.state    = ST_RUN;
              st_nxt.ss_done  = 1'b1;
              st_nxt.gates_on = 1'b1;
            end
          end else begin
            st_nxt.timer = st_r.timer + 18'h1;
          end
        end
        ST_RUN: begin
          st_nxt.gates_on = 1'b1;
        end
        ST_HICCUP: begin
          if (st_r.timer == 18'(SS_STEP_CYC - 1)) begin
            st_nxt.timer = '0;
            if (st_r.ss_step == 7'(SS_STEPS - 1)) begin
              st_nxt.ss_step = '0;
              if (st_r.dummy) begin
                st_nxt.state  = ST_SOFT;
                st_nxt.dummy  = 1'b0;
                st_nxt.hiccup = 1'b0;
                st_nxt.ea_en  = 1'b1;
              end else begin
                st_nxt.dummy = 1'b1;
              end
            end else begin
              st_nxt.ss_step = st_r.ss_step + 7'h1;
            end
          end else begin
            st_nxt.timer = st_r.timer + 18'h1;
          end
        end
        default: begin
          st_nxt.state = ST_WAIT;
        end
      endcase
      if ((st_r.state == ST_SOFT || st_r.state == ST_RUN) && trip_v) begin
        st_nxt.state    = ST_HICCUP;
        st_nxt.gates_on = 1'b0;
        st_nxt.ea_en    = 1'b0;
        st_nxt.ss_step  = '0;
        st_nxt.timer    = '0;
        st_nxt.dummy    = 1'b0;
        st_nxt.ss_done  = 1'b0;
        st_nxt.hiccup   = 1'b1;
      end
    end
    st_nxt.ss_ref = (st_nxt.state == ST_SOFT || st_nxt.state == ST_RUN) ? st_nxt.ss_step : '0;
    st_nxt.drv_en = !st_nxt.sense_en;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_r <= '{state: ST_WAIT, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Gate drive and low-side monitoring
  bss_lowside u_lowside (
    .sys_clk_i    (sys_clk_i),
    .rstn_i       (rstn_i),
    .switching_i  (st_r.gates_on),
    .pwm_high_i   (pwm_s),
    .tick_i       (st_r.tick),
    .stretch_en_i (!st_r.guard_off),
    .high_gate_o  (high_side_gate_o),
    .low_gate_o   (low_side_gate_o),
    .mon_o        (mon_w)
  );

  assign low_drv_en_o     = st_r.drv_en;
  assign sense_src_en_o   = st_r.sense_en;
  assign set_point_code_o = st_r.code;
  assign trip_dac_code_o  = st_r.trip_code;
  assign ss_ref_code_o    = st_r.ss_ref;
  assign ea_en_o          = st_r.ea_en;
  assign osc_run_o        = st_r.osc_run;
  assign guard_off_o      = st_r.guard_off;
  assign ss_done_o        = st_r.ss_done;
  assign hiccup_o         = st_r.hiccup;

  // ==========================================================================
  // Checks
  property p_soft_entry;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(st_r.state == ST_SOFT) |-> $past(st_r.state == ST_INIT || st_r.state == ST_HICCUP);
  endproperty
  a_soft_entry: assert property (p_soft_entry) else $error("ramp before sample");
  property p_en_low;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !en_s |=> (st_r.state == ST_WAIT && !st_r.gates_on && !st_r.osc_run);
  endproperty
  a_en_low: assert property (p_en_low) else $error("enable low not honoured");
  property p_delay_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.state == ST_DELAY && st_r.timer != 18'(DELAY_CYC - 1) && live)
        |=> (st_r.state == ST_DELAY && st_r.sense_en);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delay cut short");
  property p_trip_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.state == ST_RUN && trip_v && live) |=> (st_r.state == ST_HICCUP && !st_r.gates_on);
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip not acted on");
  property p_guard_off;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.guard_off && st_r.state == ST_RUN && live) |=> (st_r.state == ST_RUN);
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("trip while guard off");
  property p_hold_code;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.state == ST_HICCUP && por_s) |=> $stable(st_r.code) && $stable(st_r.trip_code);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("set point changed in retry");
  property p_step;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.state == ST_SOFT && st_nxt.state == ST_SOFT)
        |=> (st_r.ss_step == $past(st_r.ss_step) || st_r.ss_step == $past(st_r.ss_step) + 7'h1);
  endproperty
  a_step: assert property (p_step) else $error("ramp step not unit");
  property p_prebias_high;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (st_r.state == ST_SOFT && !st_r.gates_on && !pre_s && st_r.timer != 18'(SS_STEP_CYC - 1))
        |=> !st_r.gates_on;
  endproperty
  a_prebias_high: assert property (p_prebias_high) else $error("gates on early");
  property p_trip_scale;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(st_r.state == ST_INIT) |-> (st_r.trip_code == {st_r.code, 1'b0});
  endproperty
  a_trip_scale: assert property (p_trip_scale) else $error("threshold not doubled");

endmodule // bss_seq_top

// >>> verification/bss_fet_model.sv
// Purpose: Far-side model of the power stage and sense network
// Assumes: Comparator levels derived from gate commands and bench knobs
// Notes:   Oscillator period of 83 cycles, low side on in its second half
`timescale 1ns/1ns
module bss_fet_model (
  input  wire logic       sys_clk_i,
  input  wire logic       osc_run_i,
  input  wire logic       low_gate_i,
  input  wire logic       sense_on_i,
  input  wire logic [7:0] code_i,
  input  wire logic [6:0] ramp_i,
  input  wire logic [7:0] prog_i,
  input  wire logic [6:0] vout_i,
  input  wire logic       short_i,
  input  wire logic       full_i,
  output logic            samp_o,
  output logic            prebias_o,
  output logic            trip_o,
  output logic            pwm_o
);
  // ==========================================================================
  // Oscillator-phase PWM request
  int cnt = 0;
  always @(posedge sys_clk_i) cnt <= (!osc_run_i || cnt == 82) ? 0 : cnt + 1;
  // Full duty leaves no natural low-side pulse
  assign pwm_o = osc_run_i && (full_i || cnt < 41);
  // ==========================================================================
  // Comparators of the sense network
  // code passes resistor level
  assign samp_o = sense_on_i && code_i >= prog_i;
  assign prebias_o = ramp_i > vout_i;
  assign trip_o = short_i && low_gate_i;
endmodule // bss_fet_model

// >>> verification/bss_seq_top_test.sv
// Purpose: Self-checking bench of the start-up sequencer
// Assumes: Shortened delay and ramp step through parameters
// Notes:   Far side is the power stage model
`timescale 1ns/1ns
module bss_seq_top_test;
  localparam int DLY = 40;
  localparam int STP = 20;
  localparam int SMP = bss_pkg::SAMPLE_STEP_CYC;
  logic       clk = 0, rstn = 0, por = 0, en = 0, shrt = 0, full = 0;
  logic [7:0] prog = 8'h03;
  logic [6:0] vout = 7'h00;
  logic       samp, preb, trip, pwm, hg, lg, drv, sns, ea, osc, goff, done, hic;
  logic [7:0] code;
  logic [8:0] tdac;
  logic [6:0] ref_c;
  int         fail_count = 0;
  int         checked = 0;

  initial forever #20 clk = ~clk;

  bss_seq_top #(.DELAY_CYC(DLY), .SS_STEP_CYC(STP)) bss_seq_top_inst (
    .sys_clk_i(clk), .rstn_i(rstn), .bias_por_cmp_i(por), .en_cmp_i(en),
    .samp_cmp_i(samp), .prebias_cmp_i(preb), .trip_cmp_i(trip),
    .pwm_high_cmp_i(pwm), .high_side_gate_o(hg), .low_side_gate_o(lg),
    .low_drv_en_o(drv), .sense_src_en_o(sns), .set_point_code_o(code),
    .trip_dac_code_o(tdac), .ss_ref_code_o(ref_c), .ea_en_o(ea), .osc_run_o(osc),
    .guard_off_o(goff), .ss_done_o(done), .hiccup_o(hic));

  bss_fet_model bss_fet_model_inst (
    .sys_clk_i(clk), .osc_run_i(osc), .low_gate_i(lg), .sense_on_i(sns),
    .code_i(code), .ramp_i(ref_c), .prog_i(prog), .vout_i(vout), .short_i(shrt),
    .full_i(full), .samp_o(samp), .prebias_o(preb), .trip_o(trip), .pwm_o(pwm));

  // ==========================================================================
  // Shared tasks
  task automatic test_done();
    if (fail_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return sns;
      1: return ea;
      2: return done;
      3: return hic;
      5: return lg;
      default: return hg | lg;
    endcase
  endfunction

  // Waits for a level, returns cycles spent
  task automatic wt(input int k, input logic v, output int n);
    n = 0;
    while (sig(k) !== v) begin
      @(posedge clk);
      n++;
      if (n > 70000) begin
        fail_count++;
        $display("[ERR] wait %0d expected %0h seen timeout", k, v);
        test_done();
      end
    end
  endtask

  task automatic go(input logic [7:0] p, input logic [6:0] v, input logic g);
    int n;
    prog <= p;
    vout <= v;
    en <= 1'b1;
    wt(0, 1'b1, n);
    @(posedge clk);
    chk("drv_en", 9'h0, {8'h0, drv});
    chk("osc", 9'h1, {8'h0, osc});
    wt(0, 1'b0, n);
    chk("smp_len", 9'h1, {8'h0, n > DLY + (p - 1) * SMP && n < DLY + (p + 2) * SMP});
    chk("code", {1'b0, p}, {1'b0, code});
    chk("trip_dac", {p, 1'b0}, tdac);
    chk("guard_off", {8'h0, g}, {8'h0, goff});
    wt(1, 1'b1, n);
    chk("ref_start", 9'h0, {2'h0, ref_c});
    wt(4, 1'b1, n);
    chk("pre_hold", 9'h1, {8'h0, (v > 7'd63) ? done : (ref_c > v && !done)});
    wt(2, 1'b1, n);
    chk("ref_end", 9'd64, {2'h0, ref_c});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_start();
    por <= 1'b1;
    repeat (60) @(posedge clk);
    chk("held_off", 9'h0, {8'h0, sns});
    go(8'h03, 7'h00, 1'b0);
  endtask

  task automatic t_trip();
    int n;
    shrt <= 1'b1;
    wt(3, 1'b1, n);
    repeat (2) @(posedge clk);
    chk("gates_off", 9'h0, {7'h0, hg, lg});
    wt(3, 1'b0, n);
    chk("dummy_len", 9'h1, {8'h0, n > 2 * 64 * STP - 10 && n < 2 * 64 * STP + 10});
    wt(3, 1'b1, n);
    chk("retry", 9'h1, {8'h0, hic});
    wt(3, 1'b0, n);
    shrt <= 1'b0;
    chk("no_resample", 9'h0, {8'h0, sns});
    chk("kept_code", 9'h3, {1'b0, code});
    wt(2, 1'b1, n);
  endtask

  task automatic t_reen();
    en <= 1'b0;
    repeat (8) @(posedge clk);
    chk("stopped", 9'h0, {6'h0, osc, hg, lg});
    chk("rearmed", 9'h0, {8'h0, done});
    go(8'h06, 7'h14, 1'b0);
  endtask

  task automatic t_stretch();
    int n;
    full <= 1'b1;
    repeat (8) @(posedge clk);
    wt(5, 1'b1, n);
    chk("stretch_hs", 9'h0, {8'h0, hg});
    wt(5, 1'b0, n);
    chk("stretch_w", 9'(bss_pkg::MIN_PW_CYC), 9'(n));
    full <= 1'b0;
  endtask

  task automatic t_guard();
    int n;
    por <= 1'b0;
    repeat (8) @(posedge clk);
    chk("cleared", 9'h0, {1'b0, code});
    por <= 1'b1;
    go(8'd170, 7'h46, 1'b1);
    shrt <= 1'b1;
    repeat (300) @(posedge clk);
    chk("no_trip", 9'h0, {8'h0, hic});
    full <= 1'b1;
    repeat (10) @(posedge clk);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (lg !== 1'b0) n++;
    end
    chk("no_stretch", 9'h0, 9'(n));
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_start();
    t_trip();
    t_reen();
    t_stretch();
    t_guard();
    test_done();
  end
endmodule // bss_seq_top_test
